// [logic/cfgpc_top.sv]
// What this block does
// - Test select high gives four test-port pins to JTAG, low gives them GPIO in user mode.
// - Slave SPI mode uses test-port pins as serial out, in, select, clock.
// - Master SPI drives flash select and clock, sends and receives serial data.
// - Quad SPI uses four bank-0 pins as two-way data lines 0 to 3.
// - I2C/I3C mode uses two bank-1 pins as SDA, SCL; user mode GPIO or user bus.
// - Low reconfiguration request starts a new configuration sequence.
// - Init indicator pulled low when configuration sequence begins.
// - Init indicator released after init; download starts only after release.
// - Download waits while anyone holds the init indicator low.
// - Completion indicator pulled low through configuration, released at completion.
// - Stay out of user mode until completion indicator seen high.
// - During configuration all user I/O tri-stated with weak pull-down.
// - Unused I/O stays tri-stated with pull-down after configuration.
// - Shared pins unused by selected mode tri-stated during configuration.
// - In user mode image selects GPIO or function; test pins follow select only.
// - Request low of 50 ns accepted, 25 ns or shorter ignored; the code needs two low samples, so 50 ns caught by one edge is lost.
// - Init low within 100 ns, user I/O disabled within 125 ns of request; the code does both about four clocks after it.
module cfgpc_top #(
    parameter int NUM_IO = 8,
    parameter int INIT_CYC = cfgpc_pkg::INIT_DEF_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic jtag_select,
    input wire logic [1:0] cfg_mode,
    input wire logic reconfig_request_n,
    input wire logic init_state_n_in,
    output logic init_state_n_out,
    output logic init_state_n_oe,
    input wire logic done_n_in,
    output logic done_n_out,
    output logic done_n_oe,
    input wire logic load_complete,
    output logic load_enable,
    output logic user_mode,
    input wire logic [NUM_IO-1:0] user_io_used,
    input wire logic [NUM_IO-1:0] user_io_oe,
    output logic [NUM_IO-1:0] io_oe,
    output logic [NUM_IO-1:0] io_pulldown,
    input wire logic [3:0] test_pin_in,
    output logic [3:0] test_pin_out,
    output logic [3:0] test_pin_oe,
    input wire logic [3:0] test_pin_gpio_out,
    input wire logic [3:0] test_pin_gpio_oe,
    output logic [3:0] test_pin_gpio_in,
    input wire logic jtag_tdo,
    output logic jtag_tdi,
    output logic jtag_tms,
    output logic jtag_tck,
    input wire logic slave_serial_out,
    output logic slave_serial_in,
    output logic slave_select_n,
    output logic slave_clk,
    output logic boot_flash_select_n_oe,
    output logic boot_flash_clk_oe,
    output logic boot_flash_serial_out_oe,
    input wire logic [3:0] quad_line_oe_req,
    output logic [3:0] quad_line_oe,
    output logic i2c_pins_cfg_active
);
    ////////////////////////////////////////////////////////////////////
    logic rst_n;
    logic [1:0] rst_sync_q;
    logic [1:0] rst_sync_d;

    always_comb rst_sync_d = {rst_sync_q[0], 1'b1};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end
    assign rst_n = rst_sync_q[1];

    logic [2:0] line_sync;
    logic req_n_s;
    logic init_n_s;
    logic done_n_s;

    cfgpc_sync #(.WIDTH(3)) u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .async_in({reconfig_request_n, init_state_n_in, done_n_in}),
        .sync_out(line_sync)
    );
    assign req_n_s = line_sync[2];
    assign init_n_s = line_sync[1];
    assign done_n_s = line_sync[0];

    ////////////////////////////////////////////////////////////////////
    // Sequencer. A power-up reset also starts configuration.
    cfgpc_pkg::cfgpc_state_e st_q;
    cfgpc_pkg::cfgpc_state_e st_d;
    logic [cfgpc_pkg::CNT_W-1:0] low_cnt_q;
    logic [cfgpc_pkg::CNT_W-1:0] low_cnt_d;
    logic [15:0] init_cnt_q;
    logic [15:0] init_cnt_d;
    logic req_hit;

    // Two low samples in a row; limit: a 50 ns pulse caught by one edge only is lost
    assign req_hit = !req_n_s &&
        (low_cnt_q >= cfgpc_pkg::CNT_W'(cfgpc_pkg::REQ_ACCEPT_CYC - 1));

    always_comb begin
        st_d = st_q;
        init_cnt_d = init_cnt_q;
        low_cnt_d = low_cnt_q;
        if (req_n_s) begin
            low_cnt_d = '0;
        end else if (low_cnt_q != '1) begin
            low_cnt_d = low_cnt_q + 1'b1;
        end
        case (st_q)
            cfgpc_pkg::CFGPC_ST_USER: begin
                if (req_hit) begin
                    st_d = cfgpc_pkg::CFGPC_ST_INIT;
                    init_cnt_d = '0;
                end
            end
            cfgpc_pkg::CFGPC_ST_INIT: begin
                // Held while request stays low
                if (req_n_s) begin
                    init_cnt_d = init_cnt_q + 1'b1;
                    if (init_cnt_q >= 16'(INIT_CYC - 1)) begin
                        st_d = cfgpc_pkg::CFGPC_ST_INIT_WAIT;
                    end
                end
            end
            cfgpc_pkg::CFGPC_ST_INIT_WAIT: begin
                if (init_n_s) begin
                    st_d = cfgpc_pkg::CFGPC_ST_LOAD;
                end
            end
            cfgpc_pkg::CFGPC_ST_LOAD: begin
                if (load_complete) begin
                    st_d = cfgpc_pkg::CFGPC_ST_WAKE;
                end
            end
            cfgpc_pkg::CFGPC_ST_WAKE: begin
                if (done_n_s) begin
                    st_d = cfgpc_pkg::CFGPC_ST_USER;
                end
            end
            default: st_d = cfgpc_pkg::CFGPC_ST_INIT;
        endcase
        // Request restarts configuration from any state
        if (req_hit && st_q != cfgpc_pkg::CFGPC_ST_USER) begin
            st_d = cfgpc_pkg::CFGPC_ST_INIT;
            init_cnt_d = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= cfgpc_pkg::CFGPC_ST_INIT;
            init_cnt_q <= '0;
            low_cnt_q <= '0;
        end else begin
            st_q <= st_d;
            init_cnt_q <= init_cnt_d;
            low_cnt_q <= low_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Open-drain indicators, out value always low, enable pulls
    logic cfg_active;
    logic user_q;
    logic user_d;
    logic [NUM_IO-1:0] io_oe_d;
    logic [NUM_IO-1:0] io_oe_q;
    logic [NUM_IO-1:0] io_pd_d;
    logic [NUM_IO-1:0] io_pd_q;
    cfgpc_pkg::cfgpc_mode_e mode;

    assign mode = cfgpc_pkg::cfgpc_mode_e'(cfg_mode);
    assign cfg_active = (st_q != cfgpc_pkg::CFGPC_ST_USER);
    assign init_state_n_out = 1'b0;
    assign done_n_out = 1'b0;
    // Limit: sync plus filter put the pull about four clocks after the request,
    // past the 100 ns and 125 ns budgets at a 40 ns clock
    assign init_state_n_oe = (st_q == cfgpc_pkg::CFGPC_ST_INIT);
    assign done_n_oe = cfg_active && st_q != cfgpc_pkg::CFGPC_ST_WAKE;
    assign load_enable = (st_q == cfgpc_pkg::CFGPC_ST_LOAD);

    always_comb begin
        user_d = (st_d == cfgpc_pkg::CFGPC_ST_USER);
        for (int i = 0; i < NUM_IO; i++) begin
            if (!user_d) begin
                io_oe_d[i] = 1'b0;
                io_pd_d[i] = 1'b1;
            end else begin
                io_oe_d[i] = user_io_used[i] && user_io_oe[i];
                io_pd_d[i] = !user_io_used[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            user_q <= 1'b0;
            io_oe_q <= '0;
            io_pd_q <= '1;
        end else begin
            user_q <= user_d;
            io_oe_q <= io_oe_d;
            io_pd_q <= io_pd_d;
        end
    end
    assign user_mode = user_q;
    assign io_oe = io_oe_q;
    assign io_pulldown = io_pd_q;

    ////////////////////////////////////////////////////////////////////
    // Shared configuration pin roles
    logic sspi_on;
    logic mspi_on;
    logic mqspi_on;

    assign sspi_on = cfg_active && mode == cfgpc_pkg::CFGPC_MODE_SSPI;
    assign mqspi_on = load_enable && mode == cfgpc_pkg::CFGPC_MODE_MQSPI;
    assign mspi_on = load_enable && (mode == cfgpc_pkg::CFGPC_MODE_MSPI || mqspi_on);

    // Test-port pins order: 0 out, 1 in, 2 select, 3 clock
    always_comb begin
        test_pin_out = '0;
        test_pin_oe = '0;
        test_pin_gpio_in = '0;
        jtag_tdi = 1'b0;
        jtag_tms = 1'b1;
        jtag_tck = 1'b0;
        slave_serial_in = 1'b0;
        slave_select_n = 1'b1;
        slave_clk = 1'b0;
        if (jtag_select) begin
            test_pin_out[0] = jtag_tdo;
            test_pin_oe[0] = 1'b1;
            jtag_tdi = test_pin_in[1];
            jtag_tms = test_pin_in[2];
            jtag_tck = test_pin_in[3];
        end else if (sspi_on) begin
            test_pin_out[0] = slave_serial_out;
            test_pin_oe[0] = !test_pin_in[2];
            slave_serial_in = test_pin_in[1];
            slave_select_n = test_pin_in[2];
            slave_clk = test_pin_in[3];
        end else if (user_q) begin
            test_pin_out = test_pin_gpio_out;
            test_pin_oe = test_pin_gpio_oe;
            test_pin_gpio_in = test_pin_in;
        end
    end

    assign boot_flash_select_n_oe = mspi_on;
    assign boot_flash_clk_oe = mspi_on;
    assign boot_flash_serial_out_oe = mspi_on && !mqspi_on;
    assign quad_line_oe = mqspi_on ? quad_line_oe_req : 4'h0;
    assign i2c_pins_cfg_active = cfg_active && mode == cfgpc_pkg::CFGPC_MODE_I2C;
endmodule

// [pkg/cfgpc_pkg.sv]
package cfgpc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // Request pulse width, init and I/O-disable response times
    localparam int REQ_ACCEPT_NS = 50;
    localparam int REQ_REJECT_NS = 25;
    localparam int INIT_LOW_MAX_NS = 100;
    localparam int IO_DIS_MAX_NS = 125;
    // Least time rounds up: a low seen this many samples is accepted
    localparam int REQ_ACCEPT_CYC = (REQ_ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_LOW_CYC = INIT_LOW_MAX_NS / CLK_PERIOD_NS;
    localparam int IO_DIS_CYC = IO_DIS_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam int INIT_DEF_CYC = 16;

    typedef enum logic [1:0] {
        CFGPC_MODE_MSPI,
        CFGPC_MODE_MQSPI,
        CFGPC_MODE_SSPI,
        CFGPC_MODE_I2C
    } cfgpc_mode_e;

    typedef enum {
        CFGPC_ST_USER,
        CFGPC_ST_INIT,
        CFGPC_ST_INIT_WAIT,
        CFGPC_ST_LOAD,
        CFGPC_ST_WAKE
    } cfgpc_state_e;
endpackage

// [logic/cfgpc_sync.sv]
module cfgpc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Idle high so open-drain lines read released in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// [sim/cfgpc_host_model.sv]
module cfgpc_host_model (
    input logic ref_clk,
    input logic init_state_n_oe,
    input logic done_n_oe,
    input logic load_enable,
    input logic [7:0] hold_cyc,
    output logic init_state_n_in,
    output logic done_n_in,
    output logic load_complete
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] init_hold;
    logic [7:0] done_hold;
    logic [1:0] load_cnt;
    // Board keeps each line low a while after the device lets go
    always @(posedge ref_clk) begin
        init_hold <= init_state_n_oe ? hold_cyc : init_hold - 8'(init_hold != 0);
        done_hold <= done_n_oe ? hold_cyc : done_hold - 8'(done_hold != 0);
        load_cnt <= load_enable ? load_cnt + 2'h1 : 2'h0;
    end
    // Pull-ups: a released line reads high
    assign init_state_n_in = !(init_state_n_oe || init_hold != 0);
    assign done_n_in = !(done_n_oe || done_hold != 0);
    // Slow flash: image ends four cycles into the load
    assign load_complete = load_enable && load_cnt == 2'h3;
endmodule

// [sim/cfgpc_top_asserts.sv]
module cfgpc_top_asserts #(
    parameter int NUM_IO = 8
) (
    input logic ref_clk,
    input logic nrst,
    input logic jtag_select,
    input logic [1:0] cfg_mode,
    input logic reconfig_request_n,
    input logic init_state_n_in,
    input logic init_state_n_oe,
    input logic done_n_in,
    input logic done_n_oe,
    input logic load_enable,
    input logic user_mode,
    input logic [NUM_IO-1:0] io_oe,
    input logic [NUM_IO-1:0] io_pulldown,
    input logic [3:0] test_pin_in,
    input logic jtag_tdi,
    input logic jtag_tms,
    input logic jtag_tck,
    input logic slave_select_n,
    input logic slave_clk,
    input logic boot_flash_clk_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    io_off_a:
    assert property (init_state_n_oe || load_enable |-> !io_oe && &io_pulldown) else $error("io on");
    req_start_a:
    assert property (reconfig_request_n && !$past(reconfig_request_n) && !$past(reconfig_request_n, 2)
        |-> ##[0:4] init_state_n_oe && done_n_oe && !user_mode) else $error("no restart");
    short_req_a:
    assert property (user_mode && reconfig_request_n && !$past(reconfig_request_n)
        && $past(reconfig_request_n, 2) |-> user_mode [*6]) else $error("glitch taken");
    load_gate_a:
    assert property (load_enable |-> done_n_oe && !init_state_n_oe && init_state_n_in)
        else $error("early load");
    wake_gate_a:
    assert property ($rose(user_mode) |-> $past(done_n_in) && $past(done_n_in, 2) && !done_n_oe)
        else $error("early wake");
    jtag_route_a:
    assert property (jtag_select && user_mode |-> {jtag_tck, jtag_tms, jtag_tdi} == test_pin_in[3:1])
        else $error("jtag route");
    sspi_route_a:
    assert property (cfg_mode == cfgpc_pkg::CFGPC_MODE_SSPI && load_enable && !jtag_select
        |-> {slave_clk, slave_select_n} == test_pin_in[3:2]) else $error("slave route");
    flash_pins_a:
    assert property (cfg_mode != cfgpc_pkg::CFGPC_MODE_MQSPI && load_enable
        |-> boot_flash_clk_oe == (cfg_mode == cfgpc_pkg::CFGPC_MODE_MSPI)) else $error("flash oe");
    cover property (load_enable && cfg_mode == cfgpc_pkg::CFGPC_MODE_I2C);
    cover property ($rose(user_mode));
    cover property (jtag_select && user_mode);
endmodule

bind cfgpc_top cfgpc_top_asserts #(.NUM_IO(NUM_IO)) i_cfgpc_top_asserts (.*);

// [sim/cfgpc_top_test.sv]
module cfgpc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic jtag_select = 1'b0;
    logic reconfig_request_n = 1'b1;
    logic jtag_tdo = 1'b0;
    logic slave_serial_out = 1'b0;
    logic [1:0] cfg_mode = 2'h0;
    logic [7:0] hold_cyc = 8'h05;
    logic [7:0] user_io_used = 8'h0f;
    logic [7:0] user_io_oe = 8'hff;
    logic [3:0] test_pin_in = 4'h0;
    logic [3:0] test_pin_gpio_out = 4'h0;
    logic [3:0] test_pin_gpio_oe = 4'h0;
    logic [3:0] quad_line_oe_req = 4'h5;
    logic [7:0] io_oe, io_pulldown;
    logic [3:0] test_pin_out, test_pin_oe, test_pin_gpio_in, quad_line_oe;
    logic init_state_n_in, init_state_n_out, init_state_n_oe, done_n_in, done_n_out, done_n_oe;
    logic load_complete, load_enable, user_mode, jtag_tdi, jtag_tms, jtag_tck;
    logic slave_serial_in, slave_select_n, slave_clk, i2c_pins_cfg_active;
    logic boot_flash_select_n_oe, boot_flash_clk_oe, boot_flash_serial_out_oe;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    // Short init count keeps each configuration to a few dozen cycles
    cfgpc_top #(.NUM_IO(8), .INIT_CYC(2)) i_cfgpc_top (.*);
    cfgpc_host_model i_cfgpc_host_model (.*);

    initial forever #20 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d of %0d checks", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wait_for(bit on_load);
        for (int i = 0; i < 200; i++) begin
            @(negedge ref_clk);
            if ((on_load ? load_enable : user_mode) === 1'b1) break;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_config(logic [1:0] m);
        @(posedge ref_clk);
        cfg_mode <= m;
        hold_cyc <= {6'h00, m};
        test_pin_in <= 4'he;
        reconfig_request_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reconfig_request_n <= 1'b1;
        repeat (6) @(negedge ref_clk);
        check("user_mode", user_mode, 1'b0);
        check("io_oe", io_oe, 8'h00);
        wait_for(1'b1);
        check("init_line", init_state_n_in, 1'b1);
        check("done_oe", done_n_oe, 1'b1);
        check("i2c_on", i2c_pins_cfg_active, m == cfgpc_pkg::CFGPC_MODE_I2C);
        check("load_en", load_enable, 1'b1);
        check("od_out", {init_state_n_out, done_n_out}, 2'h0);
        check("flash_cs_oe", boot_flash_select_n_oe, m < cfgpc_pkg::CFGPC_MODE_SSPI);
        check("flash_so_oe", boot_flash_serial_out_oe, m == cfgpc_pkg::CFGPC_MODE_MSPI);
        check("quad_oe", quad_line_oe, m == cfgpc_pkg::CFGPC_MODE_MQSPI ? 4'h5 : 4'h0);
        check("test_oe", test_pin_oe, 4'h0);
        check("slave_in", slave_serial_in, m == cfgpc_pkg::CFGPC_MODE_SSPI);
        wait_for(1'b0);
        check("user_mode", user_mode, 1'b1);
        check("unused_oe", io_oe & ~user_io_used, 8'h00);
        check("unused_pd", io_pulldown | user_io_used, 8'hff);
        $display("t_config mode %0d done", m);
    endtask

    task automatic t_short();
        @(posedge ref_clk);
        reconfig_request_n <= 1'b0;
        @(posedge ref_clk);
        reconfig_request_n <= 1'b1;
        repeat (10) @(negedge ref_clk);
        check("user_mode", user_mode, 1'b1);
        check("init_oe", init_state_n_oe, 1'b0);
        $display("t_short done");
    endtask

    task automatic t_pins();
        @(posedge ref_clk);
        jtag_select <= 1'b1;
        test_pin_in <= 4'ha;
        jtag_tdo <= 1'b1;
        test_pin_gpio_out <= 4'h6;
        test_pin_gpio_oe <= 4'h3;
        @(negedge ref_clk);
        check("jtag_in", {jtag_tck, jtag_tms, jtag_tdi}, 3'h5);
        check("tdo_pin", test_pin_out[0], 1'b1);
        @(posedge ref_clk);
        jtag_select <= 1'b0;
        @(negedge ref_clk);
        check("gpio_in", test_pin_gpio_in, 4'ha);
        check("gpio_out", test_pin_out, 4'h6);
        check("gpio_oe", test_pin_oe, 4'h3);
        $display("t_pins done");
    endtask

    task automatic t_powerup();
        repeat (3) @(negedge ref_clk);
        check("init_oe", init_state_n_oe, 1'b1);
        check("done_oe", done_n_oe, 1'b1);
        check("io_pd", io_pulldown, 8'hff);
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_for(1'b0);
        check("user_mode", user_mode, 1'b1);
        $display("t_powerup done");
    endtask

    initial begin
        t_powerup();
        for (int m = 0; m < 4; m++) t_config(2'(m));
        t_short();
        t_pins();
        summarize();
    end
endmodule
